/* File: rtl/plsg_defines.vh */
// Purpose: constants for the link setup and gmii block
// Assumes: 40 MHz system clock
// Notes: offsets are register indexes on the plain port
`ifndef PLSG_DEFINES_VH
`define PLSG_DEFINES_VH
`define PLSG_CLK_MHZ 40
`define PLSG_REG_BC 5'h00
`define PLSG_REG_BS 5'h01
`define PLSG_REG_PA 5'h05
`define PLSG_REG_NX 5'h06
`define PLSG_REG_GP 5'h0a
`define PLSG_REG_XC 5'h1c
`define PLSG_BC_RESET 16'h1140
`define PLSG_BC_SPD_LSB 6
`define PLSG_BC_DUPLEX 8
`define PLSG_BC_RESTART 9
`define PLSG_BC_AN_EN 12
`define PLSG_BC_SPD_MSB 13
`define PLSG_XC_AUTO_OFF 6
`define PLSG_XC_MDIX 7
`define PLSG_MODE_GMII 4'h1
`define PLSG_SKEW_MAX_NS 60
`define PLSG_T_BURST_US 16000
`define PLSG_T_PULSE_US 68
`define PLSG_T_FLP_MIN_NS 17200
`define PLSG_T_FLP_MAX_US 185
`define PLSG_T_RXB_MIN_US 6800
`define PLSG_T_RXB_MAX_US 112000
`define PLSG_T_DD_MIN_NS 35400
`define PLSG_T_DD_MAX_US 95
`define PLSG_T_NLP_MIN_US 4500
`define PLSG_T_NLP_MAX_US 30000
`define PLSG_T_LOSS_US 52000
`define PLSG_T_BREAK_US 1480000
`define PLSG_T_PD_US 830000
`define PLSG_T_LEN_US 1000000
`define PLSG_MII_DIV 8
`endif

/* File: rtl/plsg_top.v */
// Purpose: link setup control (crossover, pair fixes, negotiation) and gmii/mii
// Assumes: line dsp runs on sys_clk; gtx_clk and mac transmit pins are asynchronous
// Notes: analog path and line coding stay outside; clocks enter as inputs
`timescale 1ns/100ps
`include "plsg_defines.vh"

module plsg_top #(
  parameter T_BREAK_CYC = `PLSG_T_BREAK_US * `PLSG_CLK_MHZ,
  parameter T_PD_CYC = `PLSG_T_PD_US * `PLSG_CLK_MHZ,
  parameter T_LEN_CYC = `PLSG_T_LEN_US * `PLSG_CLK_MHZ,
  parameter T_LOSS_CYC = `PLSG_T_LOSS_US * `PLSG_CLK_MHZ,
  parameter T_BURST_CYC = `PLSG_T_BURST_US * `PLSG_CLK_MHZ,
  parameter [5:0] OWN_ABILITY = 6'h3f
)(
  input wire sys_clk,
  input wire rst_n,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [3:0] mode_strap,
  input wire ref_clock_out_strap,
  input wire ref_clk_25,
  input wire pll_clk_125,
  output wire ref_clock_out_pin,
  input wire xover_seen,
  input wire xover_partner_mdix,
  output reg line_mdix,
  input wire [7:0] chan_order_seen,
  output reg [7:0] chan_order_fix,
  input wire [27:0] pair_skew_ns,
  output reg [27:0] pair_delay_ns,
  output reg skew_fault,
  input wire [3:0] pair_inverted,
  output reg [3:0] pair_invert_fix,
  input wire page_valid,
  input wire [15:0] page_base,
  input wire [15:0] page_gig,
  input wire [9:0] own_seed,
  input wire pd_seen_100,
  input wire pd_seen_10,
  input wire line_ok,
  output reg flp_burst,
  output reg link_up,
  output reg [1:0] speed,
  output reg full_duplex,
  output reg gig_master,
  input wire gtx_clk,
  input wire tx_en,
  input wire [7:0] txd,
  input wire tx_er,
  output reg line_tx_valid,
  output reg [7:0] line_tx_data,
  output reg line_tx_err,
  input wire line_rx_valid,
  input wire [7:0] line_rx_data,
  input wire line_rx_err,
  input wire line_carrier,
  output reg rx_clk,
  output reg rx_dv,
  output reg [7:0] rxd,
  output reg rx_er,
  output reg mii_tx_clk,
  output reg crs,
  output reg col,
  output reg gmii_mode
);

// ------------------------------------------------------------
// states and helpers
// ------------------------------------------------------------
localparam ST_OFF = 3'd0; // negotiation off, forced mode
localparam ST_BREAK = 3'd1; // hold link down
localparam ST_ABIL = 3'd2; // wait for page or fixed signalling
localparam ST_PDW = 3'd3; // parallel detection wait
localparam ST_LEN = 3'd4; // link enable wait
localparam ST_UP = 3'd5; // link established

// highest common mode, 6 = none (1000f,1000h,100f,100h,10f,10h)
function [2:0] plsg_best;
  input [5:0] com;
  begin
    if (com[5]) plsg_best = 3'd0;
    else if (com[4]) plsg_best = 3'd1;
    else if (com[3]) plsg_best = 3'd2;
    else if (com[2]) plsg_best = 3'd3;
    else if (com[1]) plsg_best = 3'd4;
    else if (com[0]) plsg_best = 3'd5;
    else plsg_best = 3'd6;
  end
endfunction

// two-flop synchroniser stage holder
reg [11:0] sync1; // first stage, read only by sync2
reg [11:0] sync2;
reg gtx_prev; // previous synced gtx clock level

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg [15:0] bc; // basic_control
reg [15:0] pa; // partner_ability
reg [15:0] gp; // gigabit_partner_status
reg [1:0] xc; // crossover_control bits 7:6
reg an_done; // negotiation complete
reg partner_an; // partner negotiates
reg restart_req; // pending restart
reg [15:0] act; // active copy of basic_control
reg [2:0] state;
reg [31:0] tmr; // state interval timer
reg [31:0] btmr; // burst spacing timer
reg [31:0] ltmr; // link loss timer
reg strap_done; // straps caught once
reg ref_en; // reference clock out enable
reg [3:0] div; // mii clock divider
reg [4:0] strap_s1; // strap pins, first stage
reg [4:0] strap_s2; // strap pins, settled copy
wire spd_wr; // write that changes speed bits
wire [5:0] com; // common abilities
wire [2:0] best;
integer i;

assign spd_wr = reg_wr && reg_addr == `PLSG_REG_BC &&
  ({reg_wdata[`PLSG_BC_SPD_MSB], reg_wdata[`PLSG_BC_SPD_LSB]} !=
   {act[`PLSG_BC_SPD_MSB], act[`PLSG_BC_SPD_LSB]});
assign com = OWN_ABILITY & {page_gig[11:10], page_base[8:5]};
assign best = plsg_best(com);
// clock gated by strap only; no logic sits in the clock path beyond this
assign ref_clock_out_pin = pll_clk_125 & ref_en;

// ------------------------------------------------------------
// register write and read port
// ------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    bc <= `PLSG_BC_RESET;
    xc <= 2'h0;
    restart_req <= 1'b0;
    reg_rdata <= 16'h0000;
  end
  else
  begin
    // restart bit self clears once the fsm takes it
    if (state == ST_BREAK)
      restart_req <= 1'b0;
    if (reg_wr && reg_addr == `PLSG_REG_BC)
    begin
      bc <= reg_wdata & 16'hfdff;
      if (reg_wdata[`PLSG_BC_RESTART] || spd_wr)
        restart_req <= 1'b1;
    end
    if (reg_wr && reg_addr == `PLSG_REG_XC)
      xc <= {reg_wdata[`PLSG_XC_MDIX], reg_wdata[`PLSG_XC_AUTO_OFF]};
    reg_rdata <= 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `PLSG_REG_BC: reg_rdata <= {bc[15:10], restart_req, bc[8:0]};
        `PLSG_REG_BS: reg_rdata <= {10'h000, an_done, 1'b0, 1'b1, link_up, 2'b00};
        `PLSG_REG_PA: reg_rdata <= pa;
        `PLSG_REG_NX: reg_rdata <= {15'h0, partner_an};
        `PLSG_REG_GP: reg_rdata <= gp;
        `PLSG_REG_XC: reg_rdata <= {7'h0, line_mdix, xc, 6'h0};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
end

// ------------------------------------------------------------
// straps, caught on the first edge after reset release
// ------------------------------------------------------------
// strap pins pass two flops; no reset, so they settle while reset is held
always @(posedge sys_clk)
begin
  strap_s1 <= {mode_strap, ref_clock_out_strap};
  strap_s2 <= strap_s1;
end

// capture once; needs reset held for at least two clocks
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    strap_done <= 1'b0;
    ref_en <= 1'b0;
    gmii_mode <= 1'b0;
  end
  else if (!strap_done)
  begin
    strap_done <= 1'b1;
    ref_en <= strap_s2[0];
    gmii_mode <= (strap_s2[4:1] == `PLSG_MODE_GMII);
  end
end

// ------------------------------------------------------------
// crossover, pair order, skew and polarity
// ------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    line_mdix <= 1'b0;
    chan_order_fix <= 8'he4;
    pair_delay_ns <= 28'h0;
    skew_fault <= 1'b0;
    pair_invert_fix <= 4'h0;
  end
  else
  begin
    // mdix swaps a/b and c/d in the line front end
    if (xc[0])
      line_mdix <= xc[1];
    else if (xover_seen && !link_up)
      line_mdix <= !xover_partner_mdix;
    pair_invert_fix <= pair_inverted;
    if (speed == 2'd2)
    begin
      chan_order_fix <= chan_order_seen;
      skew_fault <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
        // pad each pair up to the late limit so all four streams align
        pair_delay_ns[i*7 +: 7] <= 7'd`PLSG_SKEW_MAX_NS - pair_skew_ns[i*7 +: 7];
        if (pair_skew_ns[i*7 +: 7] > 7'd`PLSG_SKEW_MAX_NS)
          skew_fault <= 1'b1;
      end
    end
  end
end

// ------------------------------------------------------------
// negotiation state machine and timers
// ------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    state <= ST_BREAK;
    act <= `PLSG_BC_RESET;
    tmr <= 32'h0;
    btmr <= 32'h0;
    ltmr <= 32'h0;
    flp_burst <= 1'b0;
    link_up <= 1'b0;
    an_done <= 1'b0;
    partner_an <= 1'b0;
    pa <= 16'h0;
    gp <= 16'h0;
    speed <= 2'd2;
    full_duplex <= 1'b1;
    gig_master <= 1'b0;
  end
  else
  begin
    tmr <= tmr + 32'd1;
    flp_burst <= 1'b0;
    // burst spacing only while negotiating
    if (state == ST_ABIL && act[`PLSG_BC_AN_EN])
    begin
      btmr <= (btmr >= T_BURST_CYC - 1) ? 32'h0 : btmr + 32'd1;
      flp_burst <= (btmr == 32'h0);
    end
    else
      btmr <= 32'h0;
    if (restart_req)
    begin
      state <= ST_BREAK;
      act <= bc;
      tmr <= 32'h0;
      link_up <= 1'b0;
      an_done <= 1'b0;
    end
    else
    begin
      case (state)
        ST_BREAK:
        begin
          if (tmr >= T_BREAK_CYC - 1)
          begin
            tmr <= 32'h0;
            act <= bc;
            state <= bc[`PLSG_BC_AN_EN] ? ST_ABIL : ST_OFF;
          end
        end
        ST_OFF:
        begin
          // forced mode; gigabit cannot be forced, falls back to 100
          speed <= (act[`PLSG_BC_SPD_LSB] && !act[`PLSG_BC_SPD_MSB]) ? 2'd1 :
            {1'b0, act[`PLSG_BC_SPD_MSB]};
          full_duplex <= act[`PLSG_BC_DUPLEX];
          link_up <= line_ok;
        end
        ST_ABIL:
        begin
          if (page_valid && best != 3'd6 &&
              !(best < 3'd2 && page_gig[9:0] == own_seed))
          begin
            partner_an <= 1'b1;
            pa <= page_base;
            gp <= {page_gig[15:12], page_gig[11:10], 10'h0};
            gig_master <= own_seed > page_gig[9:0];
            speed <= (best < 3'd2) ? 2'd2 : (best < 3'd4) ? 2'd1 : 2'd0;
            full_duplex <= !best[0];
            tmr <= 32'h0;
            state <= ST_LEN;
          end
          else if (pd_seen_100 || pd_seen_10)
          begin
            partner_an <= 1'b0;
            speed <= pd_seen_100 ? 2'd1 : 2'd0;
            full_duplex <= 1'b0;
            tmr <= 32'h0;
            state <= ST_PDW;
          end
        end
        ST_PDW:
        begin
          if (!(pd_seen_100 || pd_seen_10))
            state <= ST_ABIL;
          else if (tmr >= T_PD_CYC - 1)
          begin
            tmr <= 32'h0;
            state <= ST_LEN;
          end
        end
        ST_LEN:
        begin
          if (line_ok)
          begin
            state <= ST_UP;
            link_up <= 1'b1;
            an_done <= partner_an;
            ltmr <= 32'h0;
          end
          else if (tmr >= T_LEN_CYC - 1)
          begin
            tmr <= 32'h0;
            state <= ST_ABIL;
          end
        end
        ST_UP:
        begin
          ltmr <= line_ok ? 32'h0 : ltmr + 32'd1;
          if (ltmr >= T_LOSS_CYC - 1)
          begin
            // link drop applies pending settings
            link_up <= 1'b0;
            an_done <= 1'b0;
            act <= bc;
            tmr <= 32'h0;
            state <= bc[`PLSG_BC_AN_EN] ? ST_ABIL : ST_OFF;
          end
        end
        default: state <= ST_BREAK;
      endcase
    end
  end
end

// ------------------------------------------------------------
// gmii transmit: gtx clock sampled, rising edge takes the byte
// ------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    sync1 <= 12'h0;
    sync2 <= 12'h0;
    gtx_prev <= 1'b0;
    line_tx_valid <= 1'b0;
    line_tx_data <= 8'h00;
    line_tx_err <= 1'b0;
  end
  else
  begin
    sync1 <= {gtx_clk, tx_en, tx_er, txd, ref_clk_25};
    sync2 <= sync1;
    gtx_prev <= sync2[11];
    line_tx_valid <= 1'b0;
    if (sync2[11] && !gtx_prev && link_up)
    begin
      line_tx_valid <= sync2[10];
      line_tx_data <= sync2[8:1];
      line_tx_err <= sync2[9];
    end
  end
end

// ------------------------------------------------------------
// receive path, carrier and collision, mii clock
// ------------------------------------------------------------
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    rx_clk <= 1'b0;
    rx_dv <= 1'b0;
    rxd <= 8'h00;
    rx_er <= 1'b0;
    crs <= 1'b0;
    col <= 1'b0;
    div <= 4'h0;
    mii_tx_clk <= 1'b0;
  end
  else
  begin
    // data changes with the clock low so the mac sees it on the rise
    rx_clk <= 1'b0;
    if (line_rx_valid)
    begin
      rx_dv <= link_up;
      rxd <= line_rx_data;
      rx_er <= line_rx_err;
    end
    else
      rx_clk <= 1'b1;
    crs <= line_carrier || (!full_duplex && sync2[10]);
    col <= !full_duplex && line_carrier && sync2[10];
    // mii clock: divided from sys_clk, driven only in gmii mode outside gigabit
    div <= (div == 4'd`PLSG_MII_DIV - 4'd1) ? 4'h0 : div + 4'd1;
    if (div == 4'h0)
      mii_tx_clk <= gmii_mode && speed != 2'd2 && !mii_tx_clk;
  end
end

endmodule

/* File: testbench/plsg_checker.sv */
// Purpose: port assertions for plsg_top
// Assumes: bench shortens break to 20 and burst spacing to 8 cycles
// Notes: bound into plsg_top at the foot of this file
`timescale 1ns/100ps
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module plsg_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire ref_clock_out_pin,
  input wire ref_clock_out_strap,
  input wire pll_clk_125,
  input wire [3:0] pair_inverted,
  input wire [3:0] pair_invert_fix,
  input wire line_rx_valid,
  input wire [7:0] line_rx_data,
  input wire rx_dv,
  input wire [7:0] rxd,
  input wire rx_clk,
  input wire link_up,
  input wire flp_burst,
  input wire line_tx_valid,
  input wire col,
  input wire full_duplex,
  input wire gmii_mode
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_invert_follow:
    assert property ($changed(pair_inverted) |=> pair_invert_fix == $past(pair_inverted))
    else $error("polarity fix did not follow detector");
  a_rx_follow:
    assert property (line_rx_valid |=> rx_dv == $past(link_up) && !rx_clk &&
      rxd == $past(line_rx_data))
    else $error("receive byte not presented next cycle");
  a_clkout_gate:
    assert property (ref_clock_out_pin |-> pll_clk_125)
    else $error("reference clock out not gated by synth clock");
  a_clkout_on:
    assert property ($past(rst_n, 2) && ref_clock_out_strap |->
      ref_clock_out_pin == pll_clk_125)
    else $error("reference clock out missing with strap high");
  a_restart_drop:
    assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[9] |-> ##[1:2] !link_up)
    else $error("restart did not drop the link");
  a_break_hold:
    assert property ($fell(link_up) |-> !link_up [*8])
    else $error("link came back inside break time");
  a_burst_space:
    assert property (flp_burst |=> !flp_burst [*7])
    else $error("bursts closer than burst interval");
  a_col_half:
    assert property (col |-> !full_duplex)
    else $error("collision flagged in full duplex");
  a_strap_fixed:
    assert property ($changed(gmii_mode) |-> !$past(rst_n, 3))
    else $error("interface mode moved after strap capture");
  a_tx_link:
    assert property (line_tx_valid |-> link_up || $past(link_up))
    else $error("transmit byte passed with link down");
endmodule
bind plsg_top plsg_checker i_plsg_checker (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .ref_clock_out_pin(ref_clock_out_pin), .pll_clk_125(pll_clk_125),
  .ref_clock_out_strap(ref_clock_out_strap),
  .pair_inverted(pair_inverted), .pair_invert_fix(pair_invert_fix),
  .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data), .rx_dv(rx_dv), .rxd(rxd),
  .rx_clk(rx_clk), .link_up(link_up), .flp_burst(flp_burst),
  .line_tx_valid(line_tx_valid), .col(col), .full_duplex(full_duplex), .gmii_mode(gmii_mode)
);

/* File: testbench/plsg_mac_model.sv */
// Purpose: mac side of the byte transmit path
// Assumes: 200 ns transmit clock, four bytes 5a..5d a frame
// Notes: clock parked low between frames
`timescale 1ns/100ps
// ------------------------------------------------------------
// mac model
// ------------------------------------------------------------
module plsg_mac_model (
  input wire go,
  output reg gtx_clk,
  output reg tx_en,
  output reg [7:0] txd,
  output reg tx_er
);
  // idle values at time zero
  initial
  begin
    gtx_clk = 1'b0;
    tx_en = 1'b0;
    txd = 8'h00;
    tx_er = 1'b0;
  end
  // data move on the falling edge so the rising edge sees them settled
  always @(posedge go)
  begin
    #7; // keeps link clock edges off the system clock edges
    tx_en = 1'b1;
    txd = 8'h5a;
    repeat (4)
    begin
      #100 gtx_clk = 1'b1;
      #100 gtx_clk = 1'b0;
      txd = txd + 8'h01;
    end
    tx_en = 1'b0;
    txd = ~txd; // stale byte must not look valid
  end
endmodule

/* File: testbench/plsg_top_bench.sv */
// Purpose: register and traffic tests of plsg_top
// Assumes: timers shortened by parameters
// Notes: expected modes worked out from the priority list
`timescale 1ns/100ps
`include "plsg_defines.vh"
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module plsg_top_bench;
  reg sys_clk, rst_n, reg_wr, reg_rd, ref_clock_out_strap, pll_clk_125, page_valid, go;
  reg pd_seen_10, line_ok, line_rx_valid, line_rx_err, line_carrier;
  reg ref_clk_25, xover_seen, xover_partner_mdix, pd_seen_100;
  reg [4:0] reg_addr;
  reg [15:0] reg_wdata, page_base, page_gig, pb, pg;
  reg [3:0] mode_strap, pair_inverted;
  reg [7:0] chan_order_seen, line_rx_data, exp_tx;
  reg [27:0] pair_skew_ns;
  reg [9:0] own_seed;
  wire [15:0] reg_rdata;
  wire [7:0] chan_order_fix, line_tx_data, rxd, txd;
  wire [27:0] pair_delay_ns;
  wire [3:0] pair_invert_fix;
  wire [1:0] speed;
  wire ref_clock_out_pin, line_mdix, skew_fault, flp_burst, link_up, full_duplex, gig_master;
  wire gtx_clk, tx_en, tx_er, line_tx_valid, line_tx_err, rx_clk, rx_dv, rx_er;
  wire mii_tx_clk, crs, col, gmii_mode;
  integer n_errors, n_checks, n_rx, i, m;
  // short timers keep each negotiation to a few tens of cycles
  plsg_top #(.T_BREAK_CYC(20), .T_PD_CYC(20), .T_LEN_CYC(20), .T_LOSS_CYC(10),
    .T_BURST_CYC(8)) i_plsg_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_strap(mode_strap), .ref_clock_out_strap(ref_clock_out_strap),
    .ref_clk_25(ref_clk_25), .pll_clk_125(pll_clk_125), .ref_clock_out_pin(ref_clock_out_pin),
    .xover_seen(xover_seen), .xover_partner_mdix(xover_partner_mdix), .line_mdix(line_mdix),
    .chan_order_seen(chan_order_seen), .chan_order_fix(chan_order_fix),
    .pair_skew_ns(pair_skew_ns), .pair_delay_ns(pair_delay_ns), .skew_fault(skew_fault),
    .pair_inverted(pair_inverted), .pair_invert_fix(pair_invert_fix), .page_valid(page_valid),
    .page_base(page_base), .page_gig(page_gig), .own_seed(own_seed),
    .pd_seen_100(pd_seen_100), .pd_seen_10(pd_seen_10), .line_ok(line_ok),
    .flp_burst(flp_burst), .link_up(link_up), .speed(speed), .full_duplex(full_duplex),
    .gig_master(gig_master), .gtx_clk(gtx_clk), .tx_en(tx_en), .txd(txd), .tx_er(tx_er),
    .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data), .line_tx_err(line_tx_err),
    .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data), .line_rx_err(line_rx_err),
    .line_carrier(line_carrier), .rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er),
    .mii_tx_clk(mii_tx_clk), .crs(crs), .col(col), .gmii_mode(gmii_mode));
  plsg_mac_model i_plsg_mac_model (.go(go), .gtx_clk(gtx_clk), .tx_en(tx_en), .txd(txd),
    .tx_er(tx_er));
  // 40 MHz system clock and 125 MHz synth clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    pll_clk_125 = 1'b0;
    forever #4 pll_clk_125 = ~pll_clk_125;
  end
  // 25 MHz reference, only synchronised inside the block
  initial
  begin
    ref_clk_25 = 1'b0;
    forever #20 ref_clk_25 = ~ref_clk_25;
  end
  // automatic: the byte monitor and the tests may compare in one time step
  task automatic chk(input [15:0] seen, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [4:0] a, input [15:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [4:0] a, input [15:0] exp, input [15:0] mask);
  begin
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & mask, exp);
  end
  endtask
  // one received byte with error flag; dv is the expected valid flag
  task rx_byte(input [7:0] d, input dv);
  begin
    @(posedge sys_clk);
    line_rx_valid <= 1'b1;
    line_rx_data <= d;
    line_rx_err <= 1'b1;
    @(posedge sys_clk);
    line_rx_valid <= 1'b0;
    line_rx_err <= 1'b0;
    #1 chk(rxd, d);
    chk(rx_dv, dv);
    chk(rx_er, 1'b1);
    chk(rx_clk, 1'b0);
    @(posedge sys_clk);
    #1 chk(rx_clk, 1'b1);
  end
  endtask
  // bounded wait; the first cycles let the old link fall
  task link_wait;
    integer k;
  begin
    repeat (3) @(posedge sys_clk);
    for (k = 0; k < 3000 && link_up !== 1'b1; k = k + 1)
      @(posedge sys_clk);
    #1 chk(link_up, 1'b1);
  end
  endtask
  task frame(input integer n);
  begin
    exp_tx = 8'h5a;
    n_rx = 0;
    @(posedge sys_clk);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk(n_rx, n);
  end
  endtask
  task summarize;
  begin
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // every forwarded byte must continue the model's sequence
  always @(posedge sys_clk)
    if (line_tx_valid === 1'b1)
    begin
      chk(line_tx_data, exp_tx);
      exp_tx = exp_tx + 8'h01;
      n_rx = n_rx + 1;
    end
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    summarize;
  end
  initial
  begin
    {n_errors, n_checks, n_rx, reg_wr, reg_rd, reg_addr, reg_wdata, go} = 0;
    {page_valid, pd_seen_10, line_rx_valid, line_rx_err, line_carrier, line_rx_data} = 0;
    {pair_inverted, page_gig, exp_tx, xover_seen, xover_partner_mdix, pd_seen_100} = 0;
    rst_n = 1'b0;
    mode_strap = 4'h1;
    ref_clock_out_strap = 1'b1;
    line_ok = 1'b1;
    own_seed = 10'h3ff;
    chan_order_seen = 8'h1b;
    pair_skew_ns = {4{7'd10}};
    page_base = 16'h0001;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`PLSG_REG_BC, `PLSG_BC_RESET, 16'hffff);
    rd(`PLSG_REG_XC, 16'h0000, 16'h00c0);
    rd(5'h02, 16'h0000, 16'hffff);
    chk(gmii_mode, 1'b1);
    @(posedge pll_clk_125) #1 chk(ref_clock_out_pin, 1'b1);
    wr(`PLSG_REG_XC, 16'h00c0);
    rd(`PLSG_REG_XC, 16'h01c0, 16'h01c0);
    chk(line_mdix, 1'b1);
    wr(`PLSG_REG_XC, 16'h0040);
    rd(`PLSG_REG_XC, 16'h0040, 16'h01c0);
    // auto mapping back on: link is down, so the detector steers the pairs
    wr(`PLSG_REG_XC, 16'h0000);
    @(posedge sys_clk);
    xover_seen <= 1'b1;
    xover_partner_mdix <= 1'b0;
    rd(`PLSG_REG_XC, 16'h0100, 16'h01c0);
    frame(0);
    // still negotiating: one burst every 8 cycles
    m = 0;
    repeat (16)
    begin
      @(posedge sys_clk);
      #1 m = m + flp_burst;
    end
    chk(m, 2);
    @(posedge sys_clk);
    pair_inverted <= 4'h5;
    repeat (2) @(posedge sys_clk);
    #1 chk(pair_invert_fix, 4'h5);
    rx_byte(8'ha5, 1'b0);
    // each mode offered with all lower ones: the top one must win
    for (i = 0; i < 6; i = i + 1)
    begin
      pb = 16'h0001;
      pg = 16'h0001;
      for (m = i; m < 6; m = m + 1)
        if (m < 2)
          pg[11 - m] = 1'b1;
        else
          pb[10 - m] = 1'b1;
      @(posedge sys_clk);
      page_base <= pb;
      page_gig <= pg;
      page_valid <= 1'b1;
      wr(`PLSG_REG_BC, 16'h1340);
      link_wait;
      chk(speed, i < 2 ? 2'h2 : (i < 4 ? 2'h1 : 2'h0));
      chk(full_duplex, i % 2 == 0);
      rd(`PLSG_REG_PA, pb, 16'hffff);
      rd(`PLSG_REG_GP, {pg[15:10], 10'h000}, 16'hffff);
      rd(`PLSG_REG_BS, 16'h002c, 16'h002c);
      if (i == 0)
      begin
        chk(gig_master, 1'b1);
        chk(chan_order_fix, 8'h1b);
        chk(pair_delay_ns, {4{7'd50}});
        chk(skew_fault, 1'b0);
        rx_byte(8'h3c, 1'b1);
        frame(4);
      end
    end
    wr(`PLSG_REG_PA, 16'hffff);
    rd(`PLSG_REG_PA, pb, 16'hffff);
    // silent partner: parallel detection in half duplex
    @(posedge sys_clk);
    page_valid <= 1'b0;
    pd_seen_10 <= 1'b1;
    line_carrier <= 1'b1;
    wr(`PLSG_REG_BC, 16'h1340);
    link_wait;
    chk(speed, 2'h0);
    chk(full_duplex, 1'b0);
    rd(`PLSG_REG_BS, 16'h000c, 16'h002c);
    frame(4);
    #1 chk(crs, 1'b1);
    chk(col, 1'b0);
    m = mii_tx_clk;
    repeat (8) @(posedge sys_clk);
    #1 chk(mii_tx_clk, !m);
    // silent partner at 100: parallel detection again
    @(posedge sys_clk);
    pd_seen_10 <= 1'b0;
    pd_seen_100 <= 1'b1;
    wr(`PLSG_REG_BC, 16'h1340);
    link_wait;
    chk(speed, 2'h1);
    chk(full_duplex, 1'b0);
    // forced 100 full: the speed change drops the link first
    wr(`PLSG_REG_BC, 16'h2100);
    repeat (2) @(posedge sys_clk);
    chk(link_up, 1'b0);
    link_wait;
    chk(speed, 2'h1);
    chk(full_duplex, 1'b1);
    summarize;
  end
endmodule
